// >>> inc/ssc_pkg.sv
package ssc_pkg;

  // system clock and master bus speed selection
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned BUS_FAST_HZ = 400_000;
  localparam int unsigned BUS_SLOW_HZ = 100_000;
  localparam int unsigned HALF_FAST_INT = SYS_CLK_HZ / (2 * BUS_FAST_HZ);
  localparam int unsigned HALF_SLOW_INT = SYS_CLK_HZ / (2 * BUS_SLOW_HZ);
  localparam logic [8:0] BUS_HALF_FAST = 9'(HALF_FAST_INT);
  localparam logic [8:0] BUS_HALF_SLOW = 9'(HALF_SLOW_INT);

  // switch mode codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_EEPROM_INIT = 3'h1;

  // fixed bits of the two-wire addresses (bit 0 is the r/w bit)
  localparam logic [1:0] TGT_ADDR_HI = 2'h3;
  localparam logic TGT_ADDR_B4 = 1'h0;
  localparam logic [2:0] EE_ADDR_HI = 3'h5;

  // general purpose pins and their alternate functions
  localparam int GPIO_W = 11;
  localparam logic [10:0] GPIO_ALT_OUT = 11'h683;
  localparam logic [10:0] GPIO_ALT_IN = 11'h01C;
  localparam int PIN_P2_RST = 0;
  localparam int PIN_P4_RST = 1;
  localparam int PIN_IRQ0 = 2;
  localparam int PIN_GPE = 7;
  localparam int PIN_P3_RST = 9;
  localparam int PIN_P5_RST = 10;
  localparam int N_EXP = 3;
  localparam int N_DS = 4;

  // reset values
  localparam logic [10:0] GPIO_RST = 11'h000;
  localparam logic [7:0] ADDR_RST = 8'h00;

  typedef enum logic [1:0] {
    ST_RESET = 2'h0,
    ST_LATCH = 2'h1,
    ST_HOLD = 2'h3,
    ST_RUN = 2'h2
  } ssc_state_t;

  // board pins after synchronisation
  typedef struct packed {
    logic fund_n;
    logic refclk_sel;
    logic [2:0] mode;
    logic slow;
    logic cc_ds;
    logic cc_us;
    logic [3:0] ee_addr;
    logic [3:0] tgt_addr;
    logic hold;
    logic aux_dis_n;
    logic wake_in_n;
    logic tap_shift;
    logic [10:0] gpio;
  } ssc_pins_t;

  // straps caught at fundamental reset release
  typedef struct packed {
    logic refclk_125;
    logic [2:0] mode;
    logic cfg_load;
    logic mode_reserved;
    logic bus_slow;
    logic hold;
  } ssc_cfg_t;

  localparam ssc_cfg_t CFG_RST = '0;

endpackage : ssc_pkg

// >>> logic/ssc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : ssc_sync
`default_nettype wire

// >>> logic/ssc_strap_reset.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_strap_reset (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic fundamental_reset_n,
  input wire logic refclk_freq_select,
  input wire logic [2:0] switch_mode_straps,
  input wire logic master_bus_slow_strap,
  input wire logic common_clk_downstream_strap,
  input wire logic common_clk_upstream_strap,
  input wire logic [3:0] eeprom_bus_addr_straps,
  input wire logic [3:0] target_bus_addr_straps,
  input wire logic reset_hold_strap,
  input wire logic aux_power_disable_n,
  input wire logic hold_bit_clear,
  input wire logic [3:0] sclk_ds_wr,
  input wire logic [3:0] sclk_ds_wdata,
  input wire logic sclk_us_wr,
  input wire logic sclk_us_wdata,
  input wire logic wake_direction_bit,
  input wire logic wake_request,
  input wire logic wake_pin_n_i,
  input wire logic [10:0] gpio_alt_en,
  input wire logic [10:0] gpio_sw_oe,
  input wire logic [10:0] gpio_sw_out,
  input wire logic [10:0] gpio_i,
  input wire logic [3:0] port_reset_req,
  input wire logic general_event_req,
  input wire logic [2:0] expander_read_ack,
  input wire logic jtag_trst_n,
  input wire logic tap_shifting,
  output ssc_pkg::ssc_cfg_t cfg_r,
  output logic [7:0] target_addr_r,
  output logic [7:0] eeprom_addr_r,
  output logic [8:0] bus_half_period_r,
  output logic core_rst_n_r,
  output logic link_fund_reset_r,
  output logic bus_if_active_r,
  output logic reset_hold_bit_r,
  output logic [3:0] sclk_ds_r,
  output logic sclk_us_r,
  output logic aux_power_enable_r,
  output logic wake_pin_n_o_r,
  output logic wake_pin_n_oe_r,
  output logic wake_event_r,
  output logic [10:0] gpio_o_r,
  output logic [10:0] gpio_oe_r,
  output logic [10:0] gpio_in_r,
  output logic [2:0] expander_read_req_r,
  output logic tdo_oe_r,
  output logic tap_rst_n_r
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  ssc_pkg::ssc_pins_t pins_raw;
  ssc_pkg::ssc_pins_t pins_s;

  assign pins_raw = '{
    fund_n: fundamental_reset_n,
    refclk_sel: refclk_freq_select,
    mode: switch_mode_straps,
    slow: master_bus_slow_strap,
    cc_ds: common_clk_downstream_strap,
    cc_us: common_clk_upstream_strap,
    ee_addr: eeprom_bus_addr_straps,
    tgt_addr: target_bus_addr_straps,
    hold: reset_hold_strap,
    aux_dis_n: aux_power_disable_n,
    wake_in_n: wake_pin_n_i,
    tap_shift: tap_shifting,
    gpio: gpio_i
  };

  ssc_sync #(.W($bits(ssc_pkg::ssc_pins_t))) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d(pins_raw),
    .q(pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencer and strap capture
  ssc_pkg::ssc_state_t state_r, state_nxt;
  ssc_pkg::ssc_cfg_t cfg_nxt;
  logic [7:0] target_addr_nxt, eeprom_addr_nxt;
  logic [8:0] bus_half_period_nxt;
  logic core_rst_n_nxt, link_fund_reset_nxt, bus_if_active_nxt;
  logic reset_hold_bit_nxt, sclk_us_nxt, aux_power_enable_nxt;
  logic [3:0] sclk_ds_nxt;

  always_comb
  begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    target_addr_nxt = target_addr_r;
    eeprom_addr_nxt = eeprom_addr_r;
    reset_hold_bit_nxt = reset_hold_bit_r;
    sclk_ds_nxt = sclk_ds_r;
    sclk_us_nxt = sclk_us_r;
    unique case (state_r)
      ssc_pkg::ST_RESET:
        if (pins_s.fund_n)
          state_nxt = ssc_pkg::ST_LATCH;
      ssc_pkg::ST_LATCH:
      begin
        // straps caught once, on release of fundamental reset
        cfg_nxt.refclk_125 = pins_s.refclk_sel;
        cfg_nxt.mode = pins_s.mode;
        cfg_nxt.cfg_load = (pins_s.mode == ssc_pkg::MODE_EEPROM_INIT);
        cfg_nxt.mode_reserved = (pins_s.mode != ssc_pkg::MODE_NORMAL) &&
          (pins_s.mode != ssc_pkg::MODE_EEPROM_INIT);
        cfg_nxt.bus_slow = pins_s.slow;
        cfg_nxt.hold = pins_s.hold;
        target_addr_nxt = {ssc_pkg::TGT_ADDR_HI, pins_s.tgt_addr[3],
          ssc_pkg::TGT_ADDR_B4, pins_s.tgt_addr[2:0], 1'h0};
        eeprom_addr_nxt = {ssc_pkg::EE_ADDR_HI, pins_s.ee_addr,
          1'h0};
        sclk_ds_nxt = {ssc_pkg::N_DS{pins_s.cc_ds}};
        sclk_us_nxt = pins_s.cc_us;
        reset_hold_bit_nxt = pins_s.hold;
        state_nxt = pins_s.hold ? ssc_pkg::ST_HOLD : ssc_pkg::ST_RUN;
      end
      ssc_pkg::ST_HOLD:
      begin
        if (hold_bit_clear)
        begin
          reset_hold_bit_nxt = 1'h0;
          state_nxt = ssc_pkg::ST_RUN;
        end
      end
      ssc_pkg::ST_RUN:
        state_nxt = ssc_pkg::ST_RUN;
    endcase
    // software override of slot clock bits once straps are in
    if (state_r == ssc_pkg::ST_HOLD || state_r == ssc_pkg::ST_RUN)
    begin
      for (int k = 0; k < ssc_pkg::N_DS; k++)
        if (sclk_ds_wr[k])
          sclk_ds_nxt[k] = sclk_ds_wdata[k];
      if (sclk_us_wr)
        sclk_us_nxt = sclk_us_wdata;
    end
    // fundamental reset overrides state, strap config and hold bit; addresses and slot clock bits keep their values
    if (!pins_s.fund_n)
    begin
      state_nxt = ssc_pkg::ST_RESET;
      cfg_nxt = ssc_pkg::CFG_RST;
      reset_hold_bit_nxt = 1'h0;
    end
    core_rst_n_nxt = (state_nxt == ssc_pkg::ST_RUN);
    link_fund_reset_nxt = !pins_s.fund_n;
    bus_if_active_nxt = (state_nxt == ssc_pkg::ST_HOLD) ||
      (state_nxt == ssc_pkg::ST_RUN);
    bus_half_period_nxt = cfg_nxt.bus_slow ? ssc_pkg::BUS_HALF_SLOW
      : ssc_pkg::BUS_HALF_FAST;
    aux_power_enable_nxt = pins_s.aux_dis_n;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= ssc_pkg::ST_RESET;
      cfg_r <= ssc_pkg::CFG_RST;
      target_addr_r <= ssc_pkg::ADDR_RST;
      eeprom_addr_r <= ssc_pkg::ADDR_RST;
      bus_half_period_r <= ssc_pkg::BUS_HALF_FAST;
      core_rst_n_r <= 1'h0;
      link_fund_reset_r <= 1'h1;
      bus_if_active_r <= 1'h0;
      reset_hold_bit_r <= 1'h0;
      sclk_ds_r <= 4'h0;
      sclk_us_r <= 1'h0;
      aux_power_enable_r <= 1'h0;
    end
    else
    begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      target_addr_r <= target_addr_nxt;
      eeprom_addr_r <= eeprom_addr_nxt;
      bus_half_period_r <= bus_half_period_nxt;
      core_rst_n_r <= core_rst_n_nxt;
      link_fund_reset_r <= link_fund_reset_nxt;
      bus_if_active_r <= bus_if_active_nxt;
      reset_hold_bit_r <= reset_hold_bit_nxt;
      sclk_ds_r <= sclk_ds_nxt;
      sclk_us_r <= sclk_us_nxt;
      aux_power_enable_r <= aux_power_enable_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // general purpose pins, wake pin, expander requests, test pins
  logic [10:0] alt_val, gpio_o_nxt, gpio_oe_nxt;
  logic [2:0] exp_irq, exp_req_nxt;
  logic port_hold;

  assign port_hold = !core_rst_n_r;
  assign alt_val = {!(port_reset_req[3] || port_hold),
    !(port_reset_req[1] || port_hold), 1'h1, !general_event_req,
    5'h1F, !(port_reset_req[2] || port_hold),
    !(port_reset_req[0] || port_hold)};

  for (genvar i = 0; i < ssc_pkg::GPIO_W; i++)
  begin : g_pin
    // alternate function decides direction; plain pins never take one
    assign gpio_oe_nxt[i] = (gpio_alt_en[i] && ssc_pkg::GPIO_ALT_OUT[i]) ||
      (!(gpio_alt_en[i] && ssc_pkg::GPIO_ALT_IN[i]) &&
      !(gpio_alt_en[i] && ssc_pkg::GPIO_ALT_OUT[i]) &&
      gpio_sw_oe[i]);
    assign gpio_o_nxt[i] = (gpio_alt_en[i] && ssc_pkg::GPIO_ALT_OUT[i])
      ? alt_val[i] : gpio_sw_out[i];
  end

  for (genvar k = 0; k < ssc_pkg::N_EXP; k++)
  begin : g_exp
    assign exp_irq[k] = gpio_alt_en[ssc_pkg::PIN_IRQ0 + k] &&
      !pins_s.gpio[ssc_pkg::PIN_IRQ0 + k];
    // request stays until the bus engine acknowledges it
    assign exp_req_nxt[k] = expander_read_req_r[k] ? !expander_read_ack[k]
      : (exp_irq[k] && core_rst_n_r);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gpio_o_r <= ssc_pkg::GPIO_RST;
      gpio_oe_r <= ssc_pkg::GPIO_RST;
      gpio_in_r <= ssc_pkg::GPIO_RST;
      expander_read_req_r <= 3'h0;
      wake_pin_n_o_r <= 1'h0;
      wake_pin_n_oe_r <= 1'h0;
      wake_event_r <= 1'h0;
      tdo_oe_r <= 1'h0;
    end
    else
    begin
      gpio_o_r <= gpio_o_nxt;
      gpio_oe_r <= gpio_oe_nxt;
      gpio_in_r <= pins_s.gpio;
      expander_read_req_r <= exp_req_nxt;
      wake_pin_n_o_r <= 1'h0;
      wake_pin_n_oe_r <= wake_direction_bit && wake_request;
      wake_event_r <= !wake_direction_bit && !pins_s.wake_in_n;
      tdo_oe_r <= pins_s.tap_shift;
    end
  end

  // test reset: asserts at once, releases on the system clock
  logic tap_rst_meta_r;

  always_ff @(posedge mclk or negedge jtag_trst_n)
  begin
    if (!jtag_trst_n)
    begin
      tap_rst_meta_r <= 1'h0;
      tap_rst_n_r <= 1'h0;
    end
    else
    begin
      tap_rst_meta_r <= 1'h1;
      tap_rst_n_r <= tap_rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_fund_reset_core: assert property (@(posedge mclk) disable iff (!rst_b)
    !pins_s.fund_n |=> !core_rst_n_r && link_fund_reset_r
      && state_r == ssc_pkg::ST_RESET)
    else $error("fundamental reset did not reset the core");

  a_hold_keeps_reset: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == ssc_pkg::ST_HOLD |-> !core_rst_n_r && bus_if_active_r
      && reset_hold_bit_r)
    else $error("hold state lost reset or bus access");

  a_hold_release: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == ssc_pkg::ST_HOLD && hold_bit_clear && pins_s.fund_n
      |=> core_rst_n_r && !reset_hold_bit_r)
    else $error("hold clear did not release reset");

  a_hold_stays: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == ssc_pkg::ST_HOLD && !hold_bit_clear |=> !core_rst_n_r)
    else $error("reset left without hold clear");

  a_target_addr: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == ssc_pkg::ST_LATCH && pins_s.fund_n |=> target_addr_r ==
      {2'h3, $past(pins_s.tgt_addr[3]), 1'h0, $past(pins_s.tgt_addr[2:0]),
      1'h0})
    else $error("target address not formed from straps");

  a_eeprom_addr: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == ssc_pkg::ST_LATCH && pins_s.fund_n |=> eeprom_addr_r ==
      {3'h5, $past(pins_s.ee_addr), 1'h0})
    else $error("eeprom address not formed from straps");

  a_addr_held: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == ssc_pkg::ST_RUN ##1 state_r == ssc_pkg::ST_RUN
      |-> $stable(target_addr_r) && $stable(eeprom_addr_r)
      && $stable(cfg_r))
    else $error("captured straps changed while running");

  a_bus_speed: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_r.bus_slow ##1 cfg_r.bus_slow
      |-> bus_half_period_r == ssc_pkg::BUS_HALF_SLOW)
    else $error("slow strap did not select slow bus");

  a_port2_reset_pin: assert property (@(posedge mclk) disable iff (!rst_b)
    gpio_alt_en[0] && port_reset_req[0] |=> gpio_oe_r[0] && !gpio_o_r[0])
    else $error("port 2 reset pin not driven low");

  a_irq_pin_input: assert property (@(posedge mclk) disable iff (!rst_b)
    gpio_alt_en[3] |=> !gpio_oe_r[3])
    else $error("expander interrupt pin is driving");

  a_expander_read: assert property (@(posedge mclk) disable iff (!rst_b)
    exp_irq[0] && core_rst_n_r && !expander_read_req_r[0]
      |=> expander_read_req_r[0])
    else $error("expander interrupt raised no read");

  a_wake_input: assert property (@(posedge mclk) disable iff (!rst_b)
    !wake_direction_bit |=> !wake_pin_n_oe_r)
    else $error("wake pin driven while set as input");

  c_hold_entered: cover property (@(posedge mclk) disable iff (!rst_b)
    state_r == ssc_pkg::ST_HOLD);
  c_hold_released: cover property (@(posedge mclk) disable iff (!rst_b)
    state_r == ssc_pkg::ST_HOLD ##1 state_r == ssc_pkg::ST_RUN);
  c_eeprom_mode: cover property (@(posedge mclk) disable iff (!rst_b)
    cfg_r.cfg_load && core_rst_n_r);
  c_expander_req: cover property (@(posedge mclk) disable iff (!rst_b)
    expander_read_req_r[0] && expander_read_ack[0]);

endmodule : ssc_strap_reset
`default_nettype wire

// >>> dv/ssc_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_board_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ack_slow,
  input wire logic [10:0] gpio_o,
  input wire logic [10:0] gpio_oe,
  input wire logic [10:0] ext_low,
  input wire logic wake_oe,
  input wire logic wake_low,
  input wire logic [2:0] exp_req,
  output logic [10:0] gpio_i,
  output logic wake_i,
  output logic [2:0] exp_ack
);
  logic [2:0][2:0] cnt_r;
  //////////////////////////////////////////////////////////////////////////
  // pins carry board pull-ups, so an undriven pin reads high
  assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & ~ext_low);
  // open-drain wake line, either side may pull it low
  assign wake_i = ~(wake_oe | wake_low);
  // expander answers a read after a short or a long delay
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      exp_ack <= 3'h0;
      cnt_r <= '0;
    end
    else
    begin
      for (int k = 0; k < 3; k++)
      begin
        exp_ack[k] <= 1'h0;
        if (exp_req[k] && !exp_ack[k])
        begin
          cnt_r[k] <= cnt_r[k] + 3'h1;
          if (cnt_r[k] == (ack_slow ? 3'h5 : 3'h0))
          begin
            exp_ack[k] <= 1'h1;
            cnt_r[k] <= 3'h0;
          end
        end
      end
    end
  end
endmodule : ssc_board_model
`default_nettype wire

// >>> dv/ssc_strap_reset_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_strap_reset_tb_top;
  logic mclk = 1'h0;
  logic rst_b, fn, rsel, slow, ccds, ccus, hold, auxn, hclr, usw, usd;
  logic wdir, wreq, wlow, gev, trn_n, shft, aslow;
  logic [2:0] mode, ack, erq;
  logic [3:0] eea, tga, dsw, dsd, prq, sds, e4, mk;
  logic [10:0] alt, soe, sout, gin, elow, go, goe, gir, am, eoe, eo, av;
  ssc_pkg::ssc_cfg_t cfg;
  logic [7:0] ta, ea;
  logic [8:0] bhp;
  logic crst, lfr, bact, hbit, sus, aux, wo, woe, wev, wi, toe, trn;
  int err_total, num_checks, cyc, i;

  ssc_strap_reset u_ssc_strap_reset (
    .mclk(mclk), .rst_b(rst_b), .fundamental_reset_n(fn),
    .refclk_freq_select(rsel), .switch_mode_straps(mode),
    .master_bus_slow_strap(slow), .common_clk_downstream_strap(ccds),
    .common_clk_upstream_strap(ccus), .eeprom_bus_addr_straps(eea),
    .target_bus_addr_straps(tga), .reset_hold_strap(hold),
    .aux_power_disable_n(auxn), .hold_bit_clear(hclr),
    .sclk_ds_wr(dsw), .sclk_ds_wdata(dsd), .sclk_us_wr(usw),
    .sclk_us_wdata(usd), .wake_direction_bit(wdir), .wake_request(wreq),
    .wake_pin_n_i(wi), .gpio_alt_en(alt), .gpio_sw_oe(soe),
    .gpio_sw_out(sout), .gpio_i(gin), .port_reset_req(prq),
    .general_event_req(gev), .expander_read_ack(ack), .jtag_trst_n(trn_n),
    .tap_shifting(shft), .cfg_r(cfg), .target_addr_r(ta),
    .eeprom_addr_r(ea), .bus_half_period_r(bhp), .core_rst_n_r(crst),
    .link_fund_reset_r(lfr), .bus_if_active_r(bact),
    .reset_hold_bit_r(hbit), .sclk_ds_r(sds), .sclk_us_r(sus),
    .aux_power_enable_r(aux), .wake_pin_n_o_r(wo), .wake_pin_n_oe_r(woe),
    .wake_event_r(wev), .gpio_o_r(go), .gpio_oe_r(goe), .gpio_in_r(gir),
    .expander_read_req_r(erq), .tdo_oe_r(toe), .tap_rst_n_r(trn)
  );

  ssc_board_model u_ssc_board_model (
    .mclk(mclk), .rst_b(rst_b), .ack_slow(aslow), .gpio_o(go),
    .gpio_oe(goe), .ext_low(elow), .wake_oe(woe), .wake_low(wlow),
    .exp_req(erq), .gpio_i(gin), .wake_i(wi), .exp_ack(ack)
  );

  //////////////////////////////////////////////////////////////////////////
  always #10 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      summarize();
    end
  end

  task automatic summarize();
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick

  task automatic wait_core(input logic v);
    i = 0;
    while (crst !== v && i < 20)
    begin
      tick(1);
      i++;
    end
    chk("core_rst_n_r", v, crst);
  endtask : wait_core

  task automatic wt(input int k, input logic v);
    i = 0;
    while (erq[k] !== v && i < 20)
    begin
      tick(1);
      i++;
    end
    chk("expander_read_req_r", v, erq[k]);
  endtask : wt

  // s = {refclk, slow, cc_ds, cc_us, eeprom[3:0], target[3:0], mode[2:0]}
  task automatic chk_cfg(input logic [14:0] s);
    logic [6:0] e7, g7;
    logic [8:0] eh;
    e7 = {s[14], s[2:0], s[2:0] == 3'h1, s[2:0] > 3'h1, s[13]};
    g7 = {cfg.refclk_125, cfg.mode, cfg.cfg_load, cfg.mode_reserved,
      cfg.bus_slow};
    eh = s[13] ? ssc_pkg::BUS_HALF_SLOW : ssc_pkg::BUS_HALF_FAST;
    chk("cfg_r", e7, g7);
    chk("bus_half_period_r", eh, bhp);
    chk("target_addr_r", {2'h3, s[6], 1'h0, s[5:3], 1'h0}, ta);
    chk("eeprom_addr_r", {3'h5, s[10:7], 1'h0}, ea);
    chk("sclk_ds_r", {4{s[12]}}, sds);
    chk("sclk_us_r", s[11], sus);
    chk("bus_if_active_r", 1, bact);
  endtask : chk_cfg

  task automatic boot(input logic [2:0] m, input logic h);
    logic [14:0] s;
    fn = 1'h0;
    {rsel, slow, ccds, ccus, eea, tga} = 12'($urandom);
    mode = m;
    hold = h;
    s = {rsel, slow, ccds, ccus, eea, tga, mode};
    tick(4);
    chk("link_fund_reset_r", 1, lfr);
    chk("core_rst_n_r", 0, crst);
    fn = 1'h1;
    if (h)
    begin
      tick(8);
      chk("core_rst_n_r", 0, crst);
      chk("bus_if_active_r", 1, bact);
      chk("reset_hold_bit_r", 1, hbit);
      hclr = 1'h1;
      tick(1);
      hclr = 1'h0;
    end
    wait_core(1'h1);
    chk("reset_hold_bit_r", 0, hbit);
    chk("cfg_r.hold", h, cfg.hold);
    chk_cfg(s);
    // straps moving after release must not disturb the captured set
    {rsel, slow, ccds, ccus, eea, tga, mode} = ~s;
    tick(4);
    chk_cfg(s);
  endtask : boot

  initial
  begin
    {rst_b, fn, rsel, slow, ccds, ccus, hold, auxn, hclr, usw, usd} = 11'h0;
    {wdir, wreq, wlow, gev, trn_n, shft, aslow} = 7'h0;
    {mode, eea, tga, dsw, dsd, prq, alt, soe, sout, elow} = '0;
    void'($urandom(68));
    repeat (12) @(posedge mclk);
    #2;
    chk("core_rst_n_r", 0, crst);
    chk("link_fund_reset_r", 1, lfr);
    chk("bus_half_period_r", ssc_pkg::BUS_HALF_FAST, bhp);
    {rst_b, auxn, trn_n} = 3'h7;
    for (int m = 0; m < 8; m++)
      boot(3'(m), m == 3 || m == 6);
    dsw = 4'hF;
    dsd = 4'($urandom);
    usw = 1'h1;
    usd = 1'($urandom);
    tick(1);
    e4 = dsd;
    mk = 4'($urandom);
    dsw = mk;
    dsd = 4'($urandom);
    usw = 1'h0;
    tick(1);
    dsw = 4'h0;
    tick(1);
    chk("sclk_ds_r", (e4 & ~mk) | (dsd & mk), sds);
    chk("sclk_us_r", usd, sus);
    for (int n = 0; n < 24; n++)
    begin
      {alt, soe, sout} = 33'({$urandom, $urandom});
      {prq, gev} = 5'($urandom);
      if (n == 0)
        alt = 11'h7FF;
      tick(2);
      am = alt & 11'h69F;
      av = {~prq[3], ~prq[1], 1'h0, ~gev, 5'h0, ~prq[2], ~prq[0]};
      eoe = (alt & 11'h683) | (soe & ~am);
      eo = (alt & 11'h683 & av) | (sout & ~am);
      chk("gpio_oe_r", eoe, goe);
      chk("gpio_o_r", eo & eoe, go & eoe);
      tick(3);
      chk("gpio_in_r", gin, gir);
    end
    {alt, soe} = {11'h01C, 11'h0};
    for (int k = 0; k < 3; k++)
    begin
      aslow = k[0];
      elow = 11'h004 << k;
      wt(k, 1'h1);
      wt(k, 1'h0);
      elow = 11'h0;
      tick(16);
      chk("expander_read_req_r", 0, erq);
    end
    {wdir, wreq} = 2'h3;
    tick(2);
    chk("wake_pin_n_oe_r", 1, woe);
    chk("wake_pin_n_o_r", 0, wo);
    {wdir, wreq, wlow} = 3'h1;
    tick(4);
    chk("wake_pin_n_oe_r", 0, woe);
    chk("wake_event_r", 1, wev);
    wlow = 1'h0;
    tick(4);
    chk("wake_event_r", 0, wev);
    auxn = 1'h0;
    tick(4);
    chk("aux_power_enable_r", 0, aux);
    auxn = 1'h1;
    tick(4);
    chk("aux_power_enable_r", 1, aux);
    trn_n = 1'h0;
    #1;
    chk("tap_rst_n_r", 0, trn);
    tick(1);
    trn_n = 1'h1;
    tick(3);
    chk("tap_rst_n_r", 1, trn);
    shft = 1'h1;
    tick(5);
    chk("tdo_oe_r", 1, toe);
    shft = 1'h0;
    tick(5);
    chk("tdo_oe_r", 0, toe);
    {alt, prq, gev} = {11'h683, 4'h0, 1'h0};
    fn = 1'h0;
    tick(5);
    chk("core_rst_n_r", 0, crst);
    chk("link_fund_reset_r", 1, lfr);
    chk("gpio_o_r", 11'h080, go & 11'h683);
    chk("gpio_oe_r", 11'h683, goe & 11'h683);
    summarize();
  end
endmodule : ssc_strap_reset_tb_top
`default_nettype wire
